// ---- csd_pkg.sv ----
// Shared constants and types for the uplink channel select and codeblock decoder
package csd_pkg;
  // Start word and code structure
  localparam logic [15:0] SYNC_WORD = 16'hEB90;
  localparam logic [6:0] GEN_LOW = 7'h45;
  localparam int INFO_BITS = 56;
  localparam int PAR_BITS = 7;
  localparam int INFO_OCTETS = 7;
  localparam logic [5:0] INFO_LAST = 6'h37;
  localparam logic [5:0] PAR_LAST = 6'h3E;
  localparam logic [5:0] FILL_POS = 6'h3F;
  localparam logic [2:0] OCT_COUNT = 3'h7;
  // A unit may carry at most this many accepted codeblocks
  localparam logic [5:0] MAX_BLOCKS = 6'h25;
  // Timeout windows in system clock periods
  localparam int CLK_TO_MIN = 3932160;
  localparam int CLK_TO_MAX = 4587520;
  localparam int ACT_TO_MIN = 334233600;
  localparam int ACT_TO_MAX = 335399960;
  // Reset values
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_INACTIVE = 2'b00,
    ST_SEARCH = 2'b01,
    ST_DECODE = 2'b10
  } csd_state_e;

  // One clean information octet towards the transfer layer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } csd_octet_s;

  // Frame framing indications towards the transfer layer
  typedef struct packed {
    logic frame;
    logic frame_end;
    logic discard;
  } csd_frame_s;
endpackage

// ---- csd_decoder.sv ----
// Six-input start word search, channel selection and codeblock decoding
//
// Behaviour
// - Start word EB90, EB octet first.
// - Start word tolerates one wrong bit.
// - Complemented start word inverts bits until tail.
// - Search runs on active, non-ignored inputs; under priority lock only on the held channel.
// - Lock first hit; restart on tail/reject.
// - Missing bit clock edges release the channel.
// - Missing start words fire activity timeout.
// - Codeblock: 7 info octets, parity, filler.
// - BCH(63,56) syndrome, g=x7+x6+x2+1.
// - Uncomplement received parity before comparing.
// - Accept clean blocks, reject even errors.
// - Odd errors: correct if filler zero.
// - Any rejection acts as tail, stops forwarding.
// - Forward clean octets in order.
// - Priority input low: all channels equal.
// - Priority mode: channel zero preempts immediately.
// - Channel zero held until release event.
// - Timeout-released priority channel ignored until inactive.
// - Channel one preempts two to five only.
// - Over 37 blocks is a unit error.
// - Deactivation or unit error discards frame.
// - Decoding flag high in decode state.
`timescale 1ns/1ps
module csd_decoder #(
  parameter int NCH = 6,
  parameter int CLK_TIMEOUT = csd_pkg::CLK_TO_MIN + 1,
  parameter int ACT_TIMEOUT = csd_pkg::ACT_TO_MIN + 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic priority_mode_select,
  input wire logic [NCH-1:0] up_clk,
  input wire logic [NCH-1:0] up_data,
  input wire logic [NCH-1:0] up_active,
  output csd_pkg::csd_octet_s octet_o,
  output csd_pkg::csd_frame_s frame_o,
  output logic decoding_state_flag,
  output logic [2:0] sel_chan,
  output logic inverted
);

  // Refuse sizes the select logic cannot serve
  if (NCH < 2 || NCH > 8 || CLK_TIMEOUT < 2 || ACT_TIMEOUT < 2) begin : g_chk
    $error("csd_decoder: unsupported parameter value");
  end

  // Distance of a word from the start word is at most one bit
  function automatic logic near_sync(input logic [15:0] w);
    logic [15:0] x;
    logic [4:0] n;
    x = w ^ csd_pkg::SYNC_WORD;
    n = 5'h00;
    for (int k = 0; k < 16; k++) begin
      n = n + {4'h0, x[k]};
    end
    return n <= 5'h01;
  endfunction

  // Syndrome of a single error at codeword exponent k
  function automatic logic [6:0] err_syn(input int k);
    logic [6:0] r;
    r = 7'h01;
    for (int n = 0; n < k; n++) begin
      r = {r[5:0], 1'b0} ^ (r[6] ? csd_pkg::GEN_LOW : 7'h00);
    end
    return r;
  endfunction

  logic [NCH-1:0] lk_tog;
  logic [NCH-1:0] lk_bit;
  logic [NCH-1:0] tg1_q, tg2_q, tg3_q, tg4_q;
  logic [NCH-1:0] d1_q, d2_q, a1_q, a2_q;
  logic [NCH-1:0] stb, act, fresh_q, pos_hit, neg_hit, usable, elig;
  logic [15:0] sr_q [NCH];
  logic [1:0] ign_q;
  csd_pkg::csd_state_e st_q, st_d;
  logic [2:0] sel_q, sel_d;
  logic plock_q, plock_d, inv_q, inv_d;
  logic [31:0] ctmo_q, atmo_q;
  logic [5:0] bcnt_q, blk_q;
  logic [6:0] rem_q;
  logic [55:0] info_q, flip, fixed, obuf_q;
  logic chk_q, fill_q, frame_q, fend_q, disc_q, flag_q;
  logic [2:0] ocnt_q;
  csd_pkg::csd_octet_s oct_q;
  logic hit_any, hit_neg;
  logic [2:0] hit_ch;
  logic locked, deact, clk_to, act_to, clean, corr, accept, reject, unit_err;
  logic grab0, grab1, release_ev, started, sbit, sstb, any_usable;

  // Link side: each input is sampled on its own bit clock; a toggle marks each new bit.
  // Reset reaches this domain through two flops, so a stopped clock just holds it.
  for (genvar i = 0; i < NCH; i++) begin : g_link
    logic rs1_q, rs2_q, tog_q, bit_q;
    always_ff @(posedge up_clk[i]) begin
      rs1_q <= rstn;
      rs2_q <= rs1_q;
    end
    always_ff @(posedge up_clk[i]) begin
      if (!rs2_q) begin
        tog_q <= 1'b0;
        bit_q <= 1'b0;
      end else begin
        tog_q <= ~tog_q;
        bit_q <= up_data[i];
      end
    end
    assign lk_tog[i] = tog_q;
    assign lk_bit[i] = bit_q;
  end

  // Crossing into the system clock; the toggle takes one more stage than the data
  // so the data bit has settled before the strobe reads it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {tg1_q, tg2_q, tg3_q, tg4_q} <= '0;
      {d1_q, d2_q, a1_q, a2_q} <= '0;
    end else if (ce) begin
      tg1_q <= lk_tog;
      tg2_q <= tg1_q;
      tg3_q <= tg2_q;
      tg4_q <= tg3_q;
      d1_q <= lk_bit;
      d2_q <= d1_q;
      a1_q <= up_active;
      a2_q <= a1_q;
    end
  end

  assign stb = tg3_q ^ tg4_q;
  assign act = a2_q;
  assign usable = act & ~{{(NCH - 2){1'b0}}, ign_q};

  // Per-channel start word search, both polarities
  for (genvar i = 0; i < NCH; i++) begin : g_srch
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        sr_q[i] <= 16'h0000;
      end else if (ce && stb[i]) begin
        sr_q[i] <= {sr_q[i][14:0], d2_q[i]};
      end
    end
    assign pos_hit[i] = fresh_q[i] && near_sync(sr_q[i]);
    assign neg_hit[i] = fresh_q[i] && near_sync(~sr_q[i]);
    assign elig[i] = usable[i] && (!plock_q || sel_q == 3'(i));
  end

  // A word is checked once, on the cycle after its last bit arrived
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fresh_q <= '0;
    end else if (ce) begin
      fresh_q <= stb & act;
    end
  end

  // Lowest index wins a same-cycle tie; otherwise first found wins
  always_comb begin
    hit_any = 1'b0;
    hit_ch = csd_pkg::SEL_RST;
    hit_neg = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (elig[i] && (pos_hit[i] || neg_hit[i])) begin
        hit_any = 1'b1;
        hit_ch = 3'(i);
        hit_neg = neg_hit[i];
      end
    end
  end

  // Selected channel bit, with polarity applied
  assign sbit = d2_q[sel_q] ^ inv_q;
  assign sstb = stb[sel_q];
  assign any_usable = |usable;

  // Release and preemption events
  assign locked = (st_q == csd_pkg::ST_DECODE) || plock_q;
  assign deact = locked && !act[sel_q];
  assign clk_to = locked && (ctmo_q >= 32'(CLK_TIMEOUT - 1));
  assign act_to = locked && (atmo_q >= 32'(ACT_TIMEOUT - 1));
  assign grab0 = priority_mode_select && usable[0] && !(locked && sel_q == 3'h0);
  assign grab1 = priority_mode_select && usable[1] && !usable[0]
                 && !(locked && sel_q <= 3'h1);

  // Decision table on the finished codeblock; odd error count is the syndrome parity
  assign clean = (rem_q == 7'h00);
  assign corr = (^rem_q) && !fill_q;
  assign accept = chk_q && (clean || corr);
  assign reject = chk_q && !(clean || corr);
  assign unit_err = accept && (blk_q == csd_pkg::MAX_BLOCKS);
  assign release_ev = deact || clk_to || act_to || reject || unit_err;
  assign started = (blk_q != 6'h00);

  // Selection and decoder state
  always_comb begin
    st_d = st_q;
    sel_d = sel_q;
    plock_d = plock_q;
    inv_d = inv_q;
    if (grab0) begin
      st_d = csd_pkg::ST_SEARCH;
      sel_d = 3'h0;
      plock_d = 1'b1;
      inv_d = 1'b0;
    end else if (grab1) begin
      st_d = csd_pkg::ST_SEARCH;
      sel_d = 3'h1;
      plock_d = 1'b1;
      inv_d = 1'b0;
    end else if (release_ev) begin
      plock_d = 1'b0;
      inv_d = 1'b0;
      st_d = any_usable ? csd_pkg::ST_SEARCH : csd_pkg::ST_INACTIVE;
    end else if (st_q == csd_pkg::ST_DECODE) begin
      st_d = csd_pkg::ST_DECODE;
    end else if (hit_any) begin
      st_d = csd_pkg::ST_DECODE;
      sel_d = hit_ch;
      inv_d = hit_neg;
    end else begin
      st_d = (any_usable || plock_q) ? csd_pkg::ST_SEARCH : csd_pkg::ST_INACTIVE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_q <= csd_pkg::ST_INACTIVE;
      sel_q <= csd_pkg::SEL_RST;
      plock_q <= 1'b0;
      inv_q <= 1'b0;
      flag_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      sel_q <= sel_d;
      plock_q <= plock_d;
      inv_q <= inv_d;
      flag_q <= (st_d == csd_pkg::ST_DECODE);
    end
  end

  // Priority channels released by a timeout stay ignored until they drop; set wins
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ign_q <= 2'b00;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if ((clk_to || act_to) && priority_mode_select && sel_q == 3'(i)) begin
          ign_q[i] <= 1'b1;
        end else if (!act[i]) begin
          ign_q[i] <= 1'b0;
        end
      end
    end
  end

  // Bit clock watchdog: each rising edge on the selected input restarts it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctmo_q <= csd_pkg::CNT_RST;
    end else if (ce) begin
      if (!locked || sstb || grab0 || grab1 || release_ev) begin
        ctmo_q <= csd_pkg::CNT_RST;
      end else begin
        ctmo_q <= ctmo_q + 32'h0000_0001;
      end
    end
  end

  // Activity watchdog: a start word on the selected input restarts it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      atmo_q <= csd_pkg::CNT_RST;
    end else if (ce) begin
      if (!locked || grab0 || grab1 || release_ev || (hit_any && hit_ch == sel_q)) begin
        atmo_q <= csd_pkg::CNT_RST;
      end else begin
        atmo_q <= atmo_q + 32'h0000_0001;
      end
    end
  end

  // Codeblock reception: 56 info bits, 7 parity bits uncomplemented into the divider,
  // then the filler bit. Bits are far apart, so the check cycle never meets a strobe.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bcnt_q <= 6'h00;
      rem_q <= 7'h00;
      info_q <= '0;
      chk_q <= 1'b0;
      fill_q <= 1'b0;
    end else if (ce) begin
      chk_q <= 1'b0;
      if (st_q != csd_pkg::ST_DECODE || chk_q) begin
        bcnt_q <= 6'h00;
        rem_q <= 7'h00;
      end else if (sstb) begin
        bcnt_q <= bcnt_q + 6'h01;
        if (bcnt_q <= csd_pkg::INFO_LAST) begin
          info_q <= {info_q[54:0], sbit};
          rem_q <= {rem_q[5:0], sbit} ^ (rem_q[6] ? csd_pkg::GEN_LOW : 7'h00);
        end else if (bcnt_q <= csd_pkg::PAR_LAST) begin
          rem_q <= {rem_q[5:0], ~sbit} ^ (rem_q[6] ? csd_pkg::GEN_LOW : 7'h00);
        end else begin
          fill_q <= sbit;
          chk_q <= 1'b1;
        end
      end
    end
  end

  // Single-error correction mask over the information bits
  for (genvar j = 0; j < csd_pkg::INFO_BITS; j++) begin : g_fix
    assign flip[j] = (rem_q == err_syn(j + csd_pkg::PAR_BITS));
  end
  assign fixed = info_q ^ (corr ? flip : 56'h00_0000_0000_0000);

  // Accepted block count and frame indications
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      blk_q <= 6'h00;
      frame_q <= 1'b0;
      fend_q <= 1'b0;
      disc_q <= 1'b0;
    end else if (ce) begin
      fend_q <= reject && started;
      disc_q <= started && (grab0 || grab1 || deact || clk_to || act_to || unit_err);
      if (grab0 || grab1 || release_ev || st_q != csd_pkg::ST_DECODE) begin
        blk_q <= 6'h00;
        frame_q <= 1'b0;
      end else if (accept) begin
        blk_q <= blk_q + 6'h01;
        frame_q <= 1'b1;
      end
    end
  end

  // Octet forwarding: one octet a cycle, oldest first; dropped on any abort
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      obuf_q <= '0;
      ocnt_q <= 3'h0;
      oct_q <= '0;
    end else if (ce) begin
      oct_q.valid <= 1'b0;
      if (grab0 || grab1 || deact || clk_to || act_to || unit_err) begin
        ocnt_q <= 3'h0;
      end else if (accept) begin
        obuf_q <= fixed;
        ocnt_q <= csd_pkg::OCT_COUNT;
      end else if (ocnt_q != 3'h0) begin
        oct_q.valid <= 1'b1;
        oct_q.data <= obuf_q[55:48];
        obuf_q <= {obuf_q[47:0], 8'h00};
        ocnt_q <= ocnt_q - 3'h1;
      end
    end
  end

  assign octet_o = oct_q;
  assign frame_o = '{frame: frame_q, frame_end: fend_q, discard: disc_q};
  assign decoding_state_flag = flag_q;
  assign sel_chan = sel_q;
  assign inverted = inv_q;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  property p_flag;
    decoding_state_flag == (st_q == csd_pkg::ST_DECODE);
  endproperty
  a_flag: assert property (p_flag) else $error("decoding flag disagrees with state");

  property p_sync_one;
    (fresh_q[0] && $countones(sr_q[0] ^ csd_pkg::SYNC_WORD) == 1) |-> pos_hit[0];
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("one-bit start word missed");

  property p_lock;
    (ce && st_q == csd_pkg::ST_SEARCH && hit_any && !grab0 && !grab1 && !release_ev)
      |=> (st_q == csd_pkg::ST_DECODE && sel_q == $past(hit_ch) && inv_q == $past(hit_neg));
  endproperty
  a_lock: assert property (p_lock) else $error("start word did not lock channel");

  property p_even_rej;
    (chk_q && rem_q != 7'h00 && !(^rem_q)) |-> reject;
  endproperty
  a_even_rej: assert property (p_even_rej) else $error("even error block accepted");

  property p_fill_rej;
    (chk_q && fill_q && rem_q != 7'h00) |-> reject;
  endproperty
  a_fill_rej: assert property (p_fill_rej) else $error("filler one block accepted");

  property p_rej_quiet;
    (ce && reject) |=> !octet_o.valid [*8];
  endproperty
  a_rej_quiet: assert property (p_rej_quiet) else $error("octet forwarded after rejection");

  property p_fwd;
    (ce && ocnt_q != 3'h0 && !grab0 && !grab1 && !deact && !clk_to && !act_to && !accept)
      |=> (octet_o.valid && octet_o.data == $past(obuf_q[55:48]));
  endproperty
  a_fwd: assert property (p_fwd) else $error("octet not forwarded in order");

  property p_unit;
    (ce && unit_err) |=> (frame_o.discard && st_q != csd_pkg::ST_DECODE && blk_q == 6'h00);
  endproperty
  a_unit: assert property (p_unit) else $error("unit error not handled");

  property p_prio0;
    (ce && grab0) |=> (sel_q == 3'h0 && plock_q && st_q == csd_pkg::ST_SEARCH);
  endproperty
  a_prio0: assert property (p_prio0) else $error("channel zero not preempting");

  property p_prio1;
    (ce && grab1) |=> (sel_q == 3'h1 && plock_q);
  endproperty
  a_prio1: assert property (p_prio1) else $error("channel one not preempting");

  property p_ign;
    (ce && clk_to && priority_mode_select && sel_q == 3'h0) |=> (ign_q[0] && !plock_q);
  endproperty
  a_ign: assert property (p_ign) else $error("timed out channel not ignored");

  property p_ctmo;
    ctmo_q < 32'(CLK_TIMEOUT);
  endproperty
  a_ctmo: assert property (p_ctmo) else $error("clock timeout overran");

  c_lock: cover property (st_q == csd_pkg::ST_SEARCH ##1 st_q == csd_pkg::ST_DECODE);
  c_inv: cover property (st_q == csd_pkg::ST_DECODE && inv_q);
  c_corr: cover property (accept && !clean);
  c_tail: cover property (reject && started);

endmodule

// ---- csd_uplink_model.sv ----
// Demodulator side model: gated bit clocks, NRZ data and activity levels
`timescale 1ns/1ps
module csd_uplink_model #(
  parameter int NCH = 6
) (
  output logic [NCH-1:0] up_clk,
  output logic [NCH-1:0] up_data,
  output logic [NCH-1:0] up_active
);
  logic link_clk;
  logic [NCH-1:0] run_q;

  // Link oscillator, 64 ns, phase unrelated to the system clock.
  // The sender's rate ceiling only applies with authentication, which lies outside this block
  initial begin
    link_clk = 1'b0;
    #11.3;
    forever #32 link_clk = ~link_clk;
  end

  // Gates change only while the oscillator is low, so no runt edges
  assign up_clk = run_q & {NCH{link_clk}};

  initial begin
    run_q = '0;
    up_data = '0;
    up_active = '0;
  end

  // Bits go out MSB first, data set half a period before the sampling edge
  task automatic send(input int ch, input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge link_clk);
      up_data[ch] = v[i];
      run_q[ch] = 1'b1;
    end
    @(negedge link_clk);
    run_q[ch] = 1'b0;
    // A released line must not keep showing the last bit
    up_data[ch] = ~up_data[ch];
  endtask

  // A few edges on every channel so the link flops leave their power-up state
  task automatic warm();
    @(negedge link_clk);
    run_q = '1;
    repeat (3) @(negedge link_clk);
    run_q = '0;
  endtask

  task automatic set_active(input int ch, input logic v);
    @(negedge link_clk);
    up_active[ch] = v;
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for uplink channel selection and codeblock decoding
`timescale 1ns/1ps
module tb_top;
  localparam int CLK_TO = 200;
  logic sys_clk;
  logic rstn;
  logic ce;
  logic prio;
  logic [5:0] up_clk;
  logic [5:0] up_data;
  logic [5:0] up_active;
  csd_pkg::csd_octet_s octet_o;
  csd_pkg::csd_frame_s frame_o;
  logic flag;
  logic [2:0] sel_chan;
  logic inverted;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_disc = 0;
  int n_end = 0;
  logic [7:0] oq[$];

  // Activity watchdog spans a whole 38-block unit, so it is kept long
  csd_decoder #(.NCH(6), .CLK_TIMEOUT(CLK_TO), .ACT_TIMEOUT(60000)) csd_decoder_i (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .priority_mode_select(prio),
    .up_clk(up_clk), .up_data(up_data), .up_active(up_active),
    .octet_o(octet_o), .frame_o(frame_o), .decoding_state_flag(flag),
    .sel_chan(sel_chan), .inverted(inverted));

  csd_uplink_model #(.NCH(6)) csd_uplink_model_i (
    .up_clk(up_clk), .up_data(up_data), .up_active(up_active));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Collect octets and framing pulses; all of them last one cycle
  always @(posedge sys_clk) begin
    cycles++;
    if (octet_o.valid === 1'b1) oq.push_back(octet_o.data);
    if (frame_o.discard === 1'b1) n_disc++;
    if (frame_o.frame_end === 1'b1) n_end++;
    if (cycles == 80000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // Sample one step after the edge so design updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Sender-side parity: remainder of info times x^7 modulo the generator
  function automatic logic [6:0] bch_par(input logic [55:0] info);
    logic [6:0] r;
    logic fb;
    r = 7'h00;
    for (int i = 55; i >= 0; i--) begin
      fb = info[i] ^ r[6];
      r = {r[5:0], 1'b0} ^ (fb ? 7'h45 : 7'h00);
    end
    return r;
  endfunction

  function automatic logic [55:0] mk_info(input int k);
    return 56'h0123_4567_89AB_CD ^ {7{k[7:0]}};
  endfunction

  task automatic start_unit(input int ch, input logic inv, input logic [15:0] err);
    csd_uplink_model_i.send(ch, {48'h0, csd_pkg::SYNC_WORD ^ {16{inv}} ^ err}, 16);
  endtask

  // Parity goes out complemented, filler last
  task automatic send_blk(input int ch, input logic inv, input logic [55:0] info,
                          input logic [63:0] flip, input logic fill);
    logic [63:0] b;
    b = {info, ~bch_par(info), fill} ^ flip;
    oq.delete();
    csd_uplink_model_i.send(ch, b ^ {64{inv}}, 64);
  endtask

  task automatic expect_ok(input logic [55:0] info);
    int t;
    t = 0;
    while (oq.size() < 7 && t < 60) begin
      tick(1);
      t++;
    end
    tick(4);
    check(oq.size(), 7, "octet count");
    for (int j = 0; j < 7; j++) check(oq[j], info[55-8*j -: 8], "octet");
  endtask

  task automatic expect_rej();
    tick(40);
    check(oq.size(), 0, "octets of rejected block");
    check(flag, 0, "decode flag after reject");
  endtask

  task automatic s_reset();
    check(octet_o.valid, 0, "valid");
    check(frame_o, 0, "frame group");
    check(flag, 0, "decode flag");
    check(sel_chan, 0, "channel");
    check(inverted, 0, "polarity");
  endtask

  task automatic s_clean();
    int e;
    csd_uplink_model_i.set_active(2, 1'b1);
    start_unit(2, 1'b0, 16'h0000);
    tick(12);
    check(flag, 1, "decode flag");
    check(sel_chan, 2, "channel");
    check(inverted, 0, "polarity");
    for (int k = 0; k < 2; k++) begin
      send_blk(2, 1'b0, mk_info(k), 64'h0, 1'b0);
      expect_ok(mk_info(k));
    end
    check(frame_o.frame, 1, "frame level");
    e = n_end;
    oq.delete();
    csd_uplink_model_i.send(2, 64'h5555_5555_5555_5555, 64);
    expect_rej();
    check(n_end, e + 1, "frame end pulse");
    csd_uplink_model_i.set_active(2, 1'b0);
  endtask

  task automatic s_invert();
    csd_uplink_model_i.set_active(4, 1'b1);
    start_unit(4, 1'b1, 16'h0008);
    tick(12);
    check(flag, 1, "decode flag");
    check(inverted, 1, "polarity");
    send_blk(4, 1'b1, mk_info(5), 64'h1 << 60, 1'b0);
    expect_ok(mk_info(5));
    send_blk(4, 1'b1, mk_info(6), 64'h0000_0100_0000_0200, 1'b0);
    expect_rej();
    start_unit(4, 1'b0, 16'h0000);
    tick(12);
    check(flag, 1, "search restarted");
    send_blk(4, 1'b0, mk_info(7), 64'h1 << 40, 1'b1);
    expect_rej();
    csd_uplink_model_i.set_active(4, 1'b0);
  endtask

  task automatic s_unit_err();
    int d;
    csd_uplink_model_i.set_active(3, 1'b1);
    start_unit(3, 1'b0, 16'h0000);
    for (int k = 0; k < 37; k++) begin
      send_blk(3, 1'b0, mk_info(k), 64'h0, 1'b0);
      expect_ok(mk_info(k));
    end
    d = n_disc;
    send_blk(3, 1'b0, mk_info(37), 64'h0, 1'b0);
    expect_rej();
    check(n_disc, d + 1, "discard on unit error");
    csd_uplink_model_i.set_active(3, 1'b0);
  endtask

  task automatic s_deact();
    int d;
    csd_uplink_model_i.set_active(1, 1'b1);
    start_unit(1, 1'b0, 16'h0000);
    send_blk(1, 1'b0, mk_info(9), 64'h0, 1'b0);
    expect_ok(mk_info(9));
    d = n_disc;
    csd_uplink_model_i.set_active(1, 1'b0);
    tick(20);
    check(n_disc, d + 1, "discard on deactivation");
    check(flag, 0, "decode flag");
  endtask

  task automatic s_clk_to();
    int t;
    csd_uplink_model_i.set_active(0, 1'b1);
    start_unit(0, 1'b0, 16'h0100);
    tick(4);
    check(flag, 1, "decode flag");
    check(sel_chan, 0, "channel found with one bad bit");
    t = 0;
    while (flag === 1'b1 && t < CLK_TO + 100) begin
      tick(1);
      t++;
    end
    check(t > CLK_TO - 40 && t < CLK_TO + 20, 1, "clock timeout");
    csd_uplink_model_i.set_active(0, 1'b0);
  endtask

  task automatic s_prio();
    prio = 1'b1;
    csd_uplink_model_i.set_active(3, 1'b1);
    start_unit(3, 1'b0, 16'h0000);
    tick(12);
    check(sel_chan, 3, "channel");
    csd_uplink_model_i.set_active(1, 1'b1);
    tick(10);
    check(sel_chan, 1, "second channel takes over");
    csd_uplink_model_i.set_active(0, 1'b1);
    tick(10);
    check(sel_chan, 0, "first channel takes over");
    csd_uplink_model_i.set_active(1, 1'b0);
    tick(10);
    check(sel_chan, 0, "first channel held");
    // Channel zero has no bit clock, so its watchdog frees it and it must then stay ignored
    tick(CLK_TO);
    start_unit(3, 1'b0, 16'h0000);
    tick(12);
    check(sel_chan, 3, "timed out channel ignored");
    check(flag, 1, "decode flag");
    csd_uplink_model_i.set_active(0, 1'b0);
    csd_uplink_model_i.set_active(3, 1'b0);
    tick(1);
    prio = 1'b0;
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    prio = 1'b0;
    tick(12);
    s_reset();
    rstn = 1'b1;
    tick(2);
    // Link flops only see reset on their own clock, so reset again with the clocks running
    rstn = 1'b0;
    csd_uplink_model_i.warm();
    tick(1);
    s_reset();
    rstn = 1'b1;
    // The first two link edges after release are swallowed by the link reset stages
    csd_uplink_model_i.warm();
    tick(2);
    s_clean();
    s_invert();
    s_unit_err();
    s_deact();
    s_clk_to();
    s_prio();
    print_verdict();
  end
endmodule
